// ==== hw/manch_pkg.sv ====
// shared constants and crc helpers for the supply-line manchester link
package manch_pkg;
  // ----------------------------------------------------------------
  // clock and frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MASK_W        = 4;
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CRC_W         = 3;
  localparam int unsigned WR_LEN        = 27; // rw, mask, addr, data
  localparam int unsigned RD_LEN        = 11; // rw, mask, addr
  localparam int unsigned RSP_LEN       = 22; // id, four flags, data
  localparam int unsigned RSP_BITS      = 27; // sync, payload, crc
  localparam int unsigned CMD_WR_BITS   = 32; // sync, payload, crc
  localparam int unsigned CMD_RD_BITS   = 16;

  // ----------------------------------------------------------------
  // fixed codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  CRC_INIT     = 3'h7;
  localparam logic [5:0]  SPECIAL_ADDR = 6'h3f;
  localparam logic [15:0] ACCESS_DATA  = 16'h62d2;
  localparam logic [2:0]  PIN_RST      = 3'h1; // supply line idles high
  localparam logic [1:0]  SYNC_CODE    = 2'h0;

  // ----------------------------------------------------------------
  // crc x^3+x+1, msb first
  // ----------------------------------------------------------------
  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic d);
    crc_step = {c[1], c[0] ^ c[2] ^ d, c[2] ^ d};
  endfunction : crc_step

  // crc over the low n bits of a right-justified vector
  function automatic logic [2:0] crc_calc(input logic [26:0] v, input int n);
    logic [2:0] c;
    c = CRC_INIT;
    for (int i = 26; i >= 0; i--) begin
      if (i < n) begin
        c = crc_step(c, v[i]);
      end
    end
    crc_calc = c;
  endfunction : crc_calc
endpackage : manch_pkg

// ==== hw/manch_link_if.sv ====
// supply-line command wire and open-drain response wire between the two ends
`timescale 1ns/1ps
interface manch_link_if;
  logic cmd_line;
  logic od_out;
  logic od_oe_n;
  logic resp_line;

  // pull-up on the response wire when the device releases it
  assign resp_line = od_oe_n ? 1'b1 : od_out;

  modport dev (input cmd_line, output od_out, output od_oe_n);
  modport host (output cmd_line, input resp_line);
endinterface : manch_link_if

// ==== hw/manch_dev.sv ====
// device end: decodes supply-line commands and answers reads on the open-drain line
//
// Contract
// - falling mid-cell is one, rising is zero
// - frame opens with two zero sync bits
// - rw, mask, address, data only for writes
// - three-bit crc closes and checks every command
// - mask bit at own identity selects die
// - zero mask skips identity compare, all accept
// - identity from data-in high, chip-select low
// - valid addressed read gets open-drain response
// - status carries identity, zero when broadcast
// - broadcast flag on zero mask or spi
// - abort flag on missing edge after sync
// - overrun flag when command overlaps response
// - checksum flag after failed command crc
// - no read answers before access code
// - access code enters mode, mask ignored
// - other data at special address exits mode
// - read address picks the returned register
// - controller reads one die at a time
// - crc x3+x+1, preset 111, msb first
// - response order sync, id, flags, data, crc
// - disable bit ignores all line activity
// - entering mode stops angle output, aborts sending
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module manch_dev #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  manch_link_if.dev                        link,
  input  wire logic                        serial_disable_bit,
  input  wire logic                        spi_mode,
  input  wire logic                        di_pin,
  input  wire logic                        cs_pin,
  input  wire logic                        pwm_level,
  input  wire logic [manch_pkg::DATA_W-1:0] rd_data,
  output logic                             man_mode,
  output logic                             wr_stb,
  output logic [manch_pkg::ADDR_W-1:0]     wr_addr,
  output logic [manch_pkg::DATA_W-1:0]     wr_data,
  output logic                             rd_stb,
  output logic [manch_pkg::ADDR_W-1:0]     rd_addr
);
  import manch_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_SYNC, D_BITS} dec_state_type;
  typedef enum logic [1:0] {T_IDLE, T_FETCH, T_SEND} tx_state_type;

  // ----------------------------------------------------------------
  // pin synchronisers: line, chip-select, data-in
  // ----------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;

  assign pin_in = {di_pin, cs_pin, link.cmd_line};

  // a change counts only once stages two and three agree
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_r[g]   <= PIN_RST[g];
        s2_r[g]   <= PIN_RST[g];
        s3_r[g]   <= PIN_RST[g];
        filt_r[g] <= PIN_RST[g];
      end else begin
        s1_r[g] <= pin_in[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          filt_r[g] <= s3_r[g];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // frame decoder
  // ----------------------------------------------------------------
  dec_state_type    dstate_r;
  logic             lv_q_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] half_r;
  logic [5:0]       n_r;
  logic [29:0]      sh_r;
  logic [2:0]       crc_r;
  logic             rw_r;
  logic             fdone_r;
  logic             rise;
  logic             fall;
  logic [CNT_W+1:0] th_lo;
  logic [CNT_W+1:0] th_hi;
  logic             bit_ok;
  logic             ab_now;
  logic [5:0]       len_cur;
  logic [1:0]       die_id;

  assign die_id = filt_r[2:1];
  assign rise   = filt_r[0] & ~lv_q_r;
  assign fall   = ~filt_r[0] & lv_q_r;
  // edges before 1.5 half-bits are cell boundaries, after 2.5 the frame died
  assign th_lo  = {2'b00, half_r} + {3'b000, half_r[CNT_W-1:1]};
  assign th_hi  = {1'b0, half_r, 1'b0} + {3'b000, half_r[CNT_W-1:1]};
  assign bit_ok = (dstate_r == D_BITS) && (rise || fall) && ({2'b00, cnt_r} > th_lo);
  assign ab_now = (dstate_r == D_BITS) && ((bit_ok && n_r == 6'd0 && fall) ||
                  (!bit_ok && {2'b00, cnt_r} > th_hi));
  assign len_cur = (n_r == 6'd1) ? (fall ? 6'(RD_LEN) : 6'(WR_LEN)) :
                   (rw_r ? 6'(RD_LEN) : 6'(WR_LEN));

  always_ff @(posedge clk) begin
    if (srst) begin
      lv_q_r <= 1'b1;
    end else begin
      lv_q_r <= filt_r[0];
    end
  end

  // disable bit holds the decoder idle so the line is never looked at
  always_ff @(posedge clk) begin
    if (srst || serial_disable_bit) begin
      dstate_r <= D_IDLE;
      cnt_r    <= '0;
      half_r   <= '0;
      n_r      <= '0;
      sh_r     <= '0;
      crc_r    <= CRC_INIT;
      rw_r     <= 1'b0;
      fdone_r  <= 1'b0;
    end else begin
      fdone_r <= 1'b0;
      cnt_r   <= cnt_r + 1'b1;
      case (dstate_r)
        D_IDLE: begin
          cnt_r <= '0;
          if (fall) begin
            dstate_r <= D_SYNC;
          end
        end
        D_SYNC: begin
          if (rise) begin
            half_r   <= cnt_r + 1'b1;
            cnt_r    <= '0;
            n_r      <= '0;
            crc_r    <= CRC_INIT;
            dstate_r <= D_BITS;
          end else if (&cnt_r) begin
            dstate_r <= D_IDLE;
          end
        end
        D_BITS: begin
          if (ab_now) begin
            dstate_r <= D_IDLE;
          end else if (bit_ok) begin
            cnt_r <= '0;
            n_r   <= n_r + 6'd1;
            if (n_r != 6'd0) begin
              sh_r <= {sh_r[28:0], fall};
            end
            if (n_r == 6'd1) begin
              rw_r <= fall;
            end
            if (n_r != 6'd0 && n_r <= len_cur) begin
              crc_r <= crc_step(crc_r, fall);
            end
            if (n_r == len_cur + 6'd3) begin
              fdone_r  <= 1'b1;
              dstate_r <= D_IDLE;
            end
          end
        end
        default: dstate_r <= D_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command evaluation, one cycle after the last bit
  // ----------------------------------------------------------------
  tx_state_type       tstate_r;
  logic               crc_ok;
  logic [3:0]         f_mask;
  logic [5:0]         f_addr;
  logic [15:0]        f_data;
  logic               bcast;
  logic               hit;
  logic               special;
  logic               cmd_ok;
  logic               rd_go;
  logic               man_mode_r;

  assign crc_ok  = (sh_r[2:0] == crc_r);
  assign f_mask  = rw_r ? sh_r[12:9] : sh_r[28:25];
  assign f_addr  = rw_r ? sh_r[8:3] : sh_r[24:19];
  assign f_data  = sh_r[18:3];
  assign bcast   = (f_mask == 4'h0);
  assign hit     = bcast || f_mask[die_id];
  assign special = !rw_r && (f_addr == SPECIAL_ADDR);
  assign cmd_ok  = fdone_r && crc_ok;
  assign rd_go   = cmd_ok && rw_r && man_mode_r && hit && (tstate_r == T_IDLE);

  // access and exit codes act whatever the mask says
  always_ff @(posedge clk) begin
    if (srst) begin
      man_mode_r <= 1'b0;
    end else if (cmd_ok && special) begin
      man_mode_r <= (f_data == ACCESS_DATA);
    end
  end

  // writes reach the register side only when valid and addressed
  logic       wr_stb_r;
  logic [5:0] wr_addr_r;
  logic [15:0] wr_data_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_stb_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      wr_stb_r <= cmd_ok && !rw_r && !special && man_mode_r && hit;
      if (cmd_ok && !rw_r) begin
        wr_addr_r <= f_addr;
        wr_data_r <= f_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky error flags, cleared when reported; a new event wins
  // ----------------------------------------------------------------
  logic ae_r;
  logic ovr_r;
  logic cse_r;
  logic clr;
  assign clr = (tstate_r == T_FETCH);
  always_ff @(posedge clk) begin
    if (srst) begin
      ae_r  <= 1'b0;
      ovr_r <= 1'b0;
      cse_r <= 1'b0;
    end else begin
      ae_r  <= ab_now | (ae_r & ~clr);
      ovr_r <= (fdone_r && tstate_r != T_IDLE) | (ovr_r & ~clr);
      cse_r <= (fdone_r && !crc_ok) | (cse_r & ~clr);
    end
  end

  // ----------------------------------------------------------------
  // response transmitter at the measured half-bit
  // ----------------------------------------------------------------
  logic [26:0]      tw_r;
  logic [4:0]       tb_r;
  logic [CNT_W-1:0] hc_r;
  logic             ph_r;
  logic             bc_r;
  logic             rd_stb_r;
  logic [5:0]       rd_addr_r;
  logic [21:0]      rsp_pay;
  logic [26:0]      rsp_word;
  logic             od_oe_n_r;

  assign rsp_pay  = {(bc_r ? 2'b00 : die_id), bc_r, ae_r, ovr_r, cse_r, rd_data};
  assign rsp_word = {SYNC_CODE, rsp_pay, crc_calc({5'b00000, rsp_pay}, RSP_LEN)};

  always_ff @(posedge clk) begin
    if (srst) begin
      tstate_r  <= T_IDLE;
      tw_r      <= '0;
      tb_r      <= '0;
      hc_r      <= '0;
      ph_r      <= 1'b0;
      bc_r      <= 1'b0;
      rd_stb_r  <= 1'b0;
      rd_addr_r <= '0;
    end else begin
      rd_stb_r <= 1'b0;
      case (tstate_r)
        T_IDLE: begin
          if (rd_go) begin
            rd_stb_r  <= 1'b1;
            rd_addr_r <= f_addr;
            bc_r      <= bcast || spi_mode;
            tstate_r  <= T_FETCH;
          end
        end
        T_FETCH: begin
          tw_r     <= rsp_word;
          tb_r     <= '0;
          hc_r     <= '0;
          ph_r     <= 1'b0;
          tstate_r <= T_SEND;
        end
        T_SEND: begin
          if (!man_mode_r) begin
            tstate_r <= T_IDLE;
          end else if (hc_r == half_r - 1'b1) begin
            hc_r <= '0;
            ph_r <= ~ph_r;
            if (ph_r) begin
              tw_r <= {tw_r[25:0], 1'b0};
              tb_r <= tb_r + 5'd1;
              if (tb_r == 5'(RSP_BITS - 1)) begin
                tstate_r <= T_IDLE;
              end
            end
          end else begin
            hc_r <= hc_r + 1'b1;
          end
        end
        default: tstate_r <= T_IDLE;
      endcase
    end
  end

  // angle output silenced while in serial mode; line released when idle
  always_ff @(posedge clk) begin
    if (srst) begin
      od_oe_n_r <= 1'b1;
    end else if (tstate_r == T_SEND) begin
      od_oe_n_r <= ph_r ? ~tw_r[26] : tw_r[26];
    end else begin
      od_oe_n_r <= man_mode_r ? 1'b1 : pwm_level;
    end
  end

  assign link.od_out  = 1'b0;
  assign link.od_oe_n = od_oe_n_r;
  assign man_mode     = man_mode_r;
  assign wr_stb       = wr_stb_r;
  assign wr_addr      = wr_addr_r;
  assign wr_data      = wr_data_r;
  assign rd_stb       = rd_stb_r;
  assign rd_addr      = rd_addr_r;
endmodule : manch_dev

// ==== hw/manch_host.sv ====
// controller end: sends command frames on the supply line and decodes read responses
`timescale 1ns/1ps
module manch_host #(
  parameter int unsigned BIT_TIME_NS  = 10000,
  parameter int unsigned RSP_WAIT_CYC = 25600
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  manch_link_if.host                       link,
  input  wire logic                        cmd_valid,
  input  wire logic                        cmd_rw,
  input  wire logic [manch_pkg::MASK_W-1:0] cmd_mask,
  input  wire logic [manch_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [manch_pkg::DATA_W-1:0] cmd_data,
  output logic                             cmd_ready,
  output logic                             cmd_refused,
  output logic                             access_open,
  output logic                             rsp_valid,
  output logic [manch_pkg::RSP_LEN-1:0]    rsp_payload,
  output logic                             rsp_crc_ok,
  output logic                             rsp_timeout
);
  import manch_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SEND, H_GAP, H_WAIT} host_state_type;
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_BITS} rx_state_type;

  localparam int unsigned HALF_CYC = (BIT_TIME_NS / 2 / CLK_PERIOD_NS > 0) ?
                                     BIT_TIME_NS / 2 / CLK_PERIOD_NS : 1;
  localparam logic [15:0] HALF16 = 16'(HALF_CYC);

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  host_state_type hstate_r;
  logic [31:0]    fw_r;
  logic [5:0]     nb_r;
  logic [15:0]    hc_r;
  logic           ph_r;
  logic           line_r;
  logic           ready_r;
  logic           refused_r;
  logic           acc_r;
  logic           rd_pend_r;
  logic           rx_arm_r;
  logic           rsp_valid_r;
  logic [10:0]    rd_pay;
  logic [26:0]    wr_pay;
  logic           refuse;

  assign rd_pay = {1'b1, cmd_mask, cmd_addr};
  assign wr_pay = {1'b0, cmd_mask, cmd_addr, cmd_data};
  // reads wait for the access code and go to exactly one die
  assign refuse = cmd_rw && (!acc_r || $countones(cmd_mask) != 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      hstate_r  <= H_IDLE;
      fw_r      <= '0;
      nb_r      <= '0;
      hc_r      <= '0;
      ph_r      <= 1'b0;
      line_r    <= 1'b1;
      ready_r   <= 1'b0;
      refused_r <= 1'b0;
      acc_r     <= 1'b0;
      rd_pend_r <= 1'b0;
      rx_arm_r  <= 1'b0;
    end else begin
      refused_r <= 1'b0;
      rx_arm_r  <= 1'b0;
      line_r    <= 1'b1;
      case (hstate_r)
        H_IDLE: begin
          ready_r <= 1'b1;
          if (cmd_valid && ready_r) begin
            if (refuse) begin
              refused_r <= 1'b1;
            end else begin
              ready_r   <= 1'b0;
              hc_r      <= '0;
              ph_r      <= 1'b0;
              rd_pend_r <= cmd_rw;
              rx_arm_r  <= cmd_rw;
              hstate_r  <= H_SEND;
              if (cmd_rw) begin
                fw_r <= {SYNC_CODE, rd_pay, crc_calc({16'h0000, rd_pay}, RD_LEN), 16'h0000};
                nb_r <= 6'(CMD_RD_BITS - 1);
              end else begin
                fw_r <= {SYNC_CODE, wr_pay, crc_calc(wr_pay, WR_LEN)};
                nb_r <= 6'(CMD_WR_BITS - 1);
                if (cmd_addr == SPECIAL_ADDR) begin
                  acc_r <= (cmd_data == ACCESS_DATA);
                end
              end
            end
          end
        end
        H_SEND: begin
          line_r <= ph_r ? ~fw_r[31] : fw_r[31];
          if (hc_r == HALF16 - 16'd1) begin
            hc_r <= '0;
            ph_r <= ~ph_r;
            if (ph_r) begin
              fw_r <= {fw_r[30:0], 1'b0};
              nb_r <= nb_r - 6'd1;
              if (nb_r == 6'd0) begin
                hstate_r <= H_GAP;
              end
            end
          end else begin
            hc_r <= hc_r + 16'd1;
          end
        end
        H_GAP: begin
          // two idle half-bits so the device sees a clean frame end
          hc_r <= hc_r + 16'd1;
          if (hc_r == {HALF16[14:0], 1'b0}) begin
            hstate_r <= rd_pend_r ? H_WAIT : H_IDLE;
          end
        end
        H_WAIT: begin
          if (rsp_valid_r) begin
            rd_pend_r <= 1'b0;
            hstate_r  <= H_IDLE;
          end
        end
        default: hstate_r <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response receiver, samples the first half of each cell
  // ----------------------------------------------------------------
  rx_state_type rstate_r;
  logic         rs1_r;
  logic         rs2_r;
  logic         rs3_r;
  logic         rflt_r;
  logic         rq_r;
  logic [23:0]  rc_r;
  logic [23:0]  samp_r;
  logic [4:0]   rb_r;
  logic [26:0]  rsh_r;
  logic         rdone_r;
  logic         rto_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rs1_r  <= 1'b1;
      rs2_r  <= 1'b1;
      rs3_r  <= 1'b1;
      rflt_r <= 1'b1;
      rq_r   <= 1'b1;
    end else begin
      rs1_r <= link.resp_line;
      rs2_r <= rs1_r;
      rs3_r <= rs2_r;
      rq_r  <= rflt_r;
      if (rs2_r == rs3_r) begin
        rflt_r <= rs3_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rstate_r <= R_IDLE;
      rc_r     <= '0;
      samp_r   <= '0;
      rb_r     <= '0;
      rsh_r    <= '0;
      rdone_r  <= 1'b0;
      rto_r    <= 1'b0;
    end else begin
      rdone_r <= 1'b0;
      rc_r    <= rc_r + 24'd1;
      case (rstate_r)
        R_IDLE: begin
          rc_r <= '0;
          if (rx_arm_r) begin
            rstate_r <= R_WAIT;
          end
        end
        R_WAIT: begin
          if (!rflt_r && rq_r) begin
            rc_r     <= '0;
            samp_r   <= {9'h000, HALF16[15:1]};
            rb_r     <= '0;
            rstate_r <= R_BITS;
          end else if (rc_r == 24'(RSP_WAIT_CYC)) begin
            rdone_r  <= 1'b1;
            rto_r    <= 1'b1;
            rstate_r <= R_IDLE;
          end
        end
        R_BITS: begin
          if (rc_r == samp_r) begin
            rsh_r  <= {rsh_r[25:0], rflt_r};
            samp_r <= samp_r + {7'h00, HALF16, 1'b0};
            rb_r   <= rb_r + 5'd1;
            if (rb_r == 5'(RSP_BITS - 1)) begin
              rdone_r  <= 1'b1;
              rto_r    <= 1'b0;
              rstate_r <= R_IDLE;
            end
          end
        end
        default: rstate_r <= R_IDLE;
      endcase
    end
  end

  // response outputs held until the next response
  logic [21:0] pay_r;
  logic        crc_ok_r;
  logic        to_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_r <= 1'b0;
      pay_r       <= '0;
      crc_ok_r    <= 1'b0;
      to_r        <= 1'b0;
    end else begin
      rsp_valid_r <= rdone_r;
      if (rdone_r) begin
        pay_r    <= rsh_r[24:3];
        crc_ok_r <= !rto_r && (crc_calc({5'b00000, rsh_r[24:3]}, RSP_LEN) == rsh_r[2:0]);
        to_r     <= rto_r;
      end
    end
  end

  assign link.cmd_line = line_r;
  assign cmd_ready     = ready_r;
  assign cmd_refused   = refused_r;
  assign access_open   = acc_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_payload   = pay_r;
  assign rsp_crc_ok    = crc_ok_r;
  assign rsp_timeout   = to_r;
endmodule : manch_host

// ==== tb/manch_checker.sv ====
// link assertions between the host and device ends
`timescale 1ns/1ps
module manch_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_line,
  input wire logic od_out,
  input wire logic od_oe_n,
  input wire logic resp_line
);
  // ------------------------------
  // run-length counters
  // ------------------------------
  int cl_r;
  int rl_r;
  int ch_r;
  int oh_r;
  // low runs bound a cell; high runs tell a frame start from a mid-frame edge
  always_ff @(posedge clk) begin
    cl_r <= (srst || cmd_line) ? 0 : cl_r + 1;
    rl_r <= (srst || resp_line) ? 0 : rl_r + 1;
    ch_r <= (srst || !cmd_line) ? 0 : ch_r + 1;
    oh_r <= (srst || !od_oe_n) ? 0 : oh_r + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------------------------------
  // assertions
  // ------------------------------
  a_od_pin_low: assert property (od_out == 1'b0) else $error("od pin not low");
  a_resp_released_rst: assert property ($past(srst) |-> od_oe_n) else $error("resp driven at reset");
  a_cmd_idle_high: assert property ($past(srst) |-> cmd_line) else $error("cmd line low at reset");
  a_cmd_half_hold: assert property ($changed(cmd_line) |=> $stable(cmd_line)[*7]) else $error("short half");
  a_cmd_low_run: assert property (cl_r <= 16) else $error("cmd low too long");
  a_resp_low_run: assert property (rl_r <= 24) else $error("resp low too long");
  a_resp_half_hold: assert property ($changed(od_oe_n) |=> $stable(od_oe_n)[*5]) else $error("short resp half");
  a_resp_after_cmd: assert property ($fell(od_oe_n) && oh_r > 30 |-> ch_r < 40) else $error("stray resp");
  c_resp_start: cover property ($fell(od_oe_n) && oh_r > 30);
  c_cmd_start: cover property ($fell(cmd_line) && ch_r > 30);
  c_cmd_full_low: cover property (cl_r == 16);
endmodule : manch_checker

// ==== tb/tb.sv ====
// bench joining host and device ends over the link
`timescale 1ns/1ps
module tb;
  import manch_pkg::*;
  logic        clk, srst, cmd_valid, cmd_rw, di_pin, cs_pin, spi_mode, serial_disable_bit;
  logic [3:0]  cmd_mask;
  logic [5:0]  cmd_addr, a, wr_addr, rd_addr;
  logic [15:0] cmd_data, d, wr_data;
  logic        cmd_ready, cmd_refused, access_open, rsp_valid, rsp_crc_ok, rsp_timeout;
  logic        man_mode, wr_stb, rd_stb, got, rf, pwm_level;
  logic [21:0] rsp_payload;
  logic [1:0]  id;
  logic [3:0]  own;
  int          n_errors, checks_done, nwr, base;
  manch_link_if lnk ();
  manch_dev u_manch_dev (.clk(clk), .srst(srst), .link(lnk), .serial_disable_bit(serial_disable_bit),
    .spi_mode(spi_mode), .di_pin(di_pin), .cs_pin(cs_pin), .pwm_level(pwm_level), .rd_data(regval(rd_addr)),
    .man_mode(man_mode), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_addr(rd_addr));
  manch_host #(.BIT_TIME_NS(400), .RSP_WAIT_CYC(480)) u_manch_host (.clk(clk), .srst(srst), .link(lnk),
    .cmd_valid(cmd_valid), .cmd_rw(cmd_rw), .cmd_mask(cmd_mask), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .access_open(access_open), .rsp_valid(rsp_valid),
    .rsp_payload(rsp_payload), .rsp_crc_ok(rsp_crc_ok), .rsp_timeout(rsp_timeout));
  manch_checker u_manch_checker (.clk(clk), .srst(srst), .cmd_line(lnk.cmd_line), .od_out(lnk.od_out),
    .od_oe_n(lnk.od_oe_n), .resp_line(lnk.resp_line));
  // ------------------------------
  // helpers
  // ------------------------------
  // register contents seen by the device, distinct per address
  function automatic logic [15:0] regval(input logic [5:0] x);
    regval = {x, ~x, 4'h9};
  endfunction : regval
  // register-side strobes, writes and reads alike
  always @(posedge clk) if (wr_stb === 1'b1 || rd_stb === 1'b1) nwr <= nwr + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one command; waits for the host to finish and any reply
  task automatic xfer(input logic rw, input logic [3:0] m, input logic [5:0] ad, input logic [15:0] dt);
    int i;
    cmd_valid <= 1'b1;
    cmd_rw <= rw;
    cmd_mask <= m;
    cmd_addr <= ad;
    cmd_data <= dt;
    got = 0;
    rf = 0;
    base = nwr;
    i = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++i < 50);
    cmd_valid <= 1'b0;
    for (i = 0; i < 1500 && !(i > 2 && cmd_ready === 1'b1 && (got || rf || !rw)); i++) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) got = 1;
      if (cmd_refused === 1'b1) rf = 1;
    end
  endtask : xfer
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ------------------------------
  // clock, watchdog, sequence
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // generous: whole run is near 7k cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h117c));
    id = 2'($urandom);
    own = 4'h1 << id;
    {di_pin, cs_pin} = id;
    {srst, cmd_valid, cmd_rw, spi_mode, serial_disable_bit, pwm_level} = 6'b100001;
    {cmd_mask, cmd_addr, cmd_data} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    // short angle pulse: reaches the pin before serial mode, kept under the low-run bound
    pwm_level <= 1'b0;
    repeat (8) @(posedge clk);
    chk(lnk.resp_line, 0);
    pwm_level <= 1'b1;
    xfer(1'b1, own, 6'h20, 16'h0);
    chk(rf, 1);
    xfer(1'b0, own ^ 4'hf, SPECIAL_ADDR, ACCESS_DATA);
    chk({man_mode, access_open}, 2'b11);
    pwm_level <= 1'b0;
    repeat (2) @(posedge clk);
    chk(lnk.resp_line, 1);
    pwm_level <= 1'b1;
    // own, broadcast, other die, then own while disabled
    for (int j = 0; j < 4; j++) begin
      a = 6'($urandom % 63);
      d = 16'($urandom);
      serial_disable_bit <= (j == 3);
      xfer(1'b0, (j == 1) ? 4'h0 : (j == 2) ? own ^ 4'hf : own, a, d);
      chk(nwr - base, j < 2);
      if (j < 2) chk({wr_addr, wr_data}, {a, d});
    end
    // a read while disabled gets no answer, so the host times out
    xfer(1'b1, own, 6'h20, 16'h0);
    chk({got, rsp_timeout}, 2'b11);
    chk(nwr - base, 0);
    serial_disable_bit <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      a = 6'($urandom % 63);
      spi_mode <= (j == 3);
      xfer(1'b1, own, a, 16'h0);
      chk({got, rsp_crc_ok, rsp_timeout}, 3'b110);
      chk(nwr - base, 1);
      chk(rsp_payload, {(j == 3) ? 2'b00 : id, (j == 3) ? 4'h8 : 4'h0, regval(a)});
      chk(rd_addr, a);
    end
    spi_mode <= 1'b0;
    xfer(1'b0, own, SPECIAL_ADDR, ACCESS_DATA ^ 16'h1);
    chk({man_mode, access_open}, 2'b00);
    tally_and_finish();
  end
endmodule : tb
